// file: rtl/tpa_timer.sv
// Eight-bit timer with phase-correct PWM, crystal clocking and AXI4-Lite registers.
// Assumes crystal_osc_in is sampled on clk_sys, which runs far faster than it.
`timescale 1ns/100ps
module tpa_timer (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic arst_n,
	// AXI4-Lite write address and data
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	// AXI4-Lite write response
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// AXI4-Lite read
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Crystal and pins
	input wire logic crystal_osc_in,
	output logic compare_output_pin,
	output logic compare_output_connected,
	output logic osc_pins_claimed,
	// Processor events
	output logic timer_irq,
	output logic wake_req
);
	function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
		return a[7:2] == off[7:2];
	endfunction

	// Bus state
	logic aw_hold_r, w_hold_r, w_strb0_r, bvalid_r, rvalid_r;
	logic awready_r, wready_r, arready_r;
	logic [7:0] aw_addr_r, w_data_r;
	logic [1:0] bresp_r, rresp_r;
	logic [31:0] rdata_r;
	// Timer state
	logic [6:0] ctl_r;
	logic [7:0] cmp_r, cnt_r, cnt_copy_r;
	logic dir_up_r, async_sel_r, psr_r;
	logic [1:0] flags_r, irqen_r;
	logic [7:0] tmp_r [3];
	logic [1:0] edg_r [3];
	logic [2:0] busy_r, lat;
	logic xs1_r, xs2_r, xs3_r;
	logic [2:0] pipe_ovf_r, pipe_cmp_r;
	logic out_lvl_r, pin_r, conn_r, osc_claim_r, irq_r, rearm_r, wake_arm_r, wake_r;

	tpa_presc_if pif ();

	tpa_prescaler u_presc (
		.clk_sys(clk_sys),
		.arst_n(arst_n),
		.pif(pif)
	);

	// Bus handshake decode
	wire aw_take = s_axi_awvalid & awready_r;
	wire w_take = s_axi_wvalid & wready_r;
	wire wr_do = aw_hold_r & w_hold_r & ~bvalid_r;
	wire bvalid_nxt = wr_do | (bvalid_r & ~s_axi_bready);
	wire aw_hold_nxt = (aw_hold_r | aw_take) & ~wr_do;
	wire w_hold_nxt = (w_hold_r | w_take) & ~wr_do;
	wire ar_take = s_axi_arvalid & arready_r;
	wire rvalid_nxt = ar_take | (rvalid_r & ~s_axi_rready);
	wire wr_en = wr_do & w_strb0_r;
	wire wr_map = hit(aw_addr_r, tpa_pkg::OFF_CTRL) | hit(aw_addr_r, tpa_pkg::OFF_COUNT)
		| hit(aw_addr_r, tpa_pkg::OFF_COMPARE) | hit(aw_addr_r, tpa_pkg::OFF_ASR)
		| hit(aw_addr_r, tpa_pkg::OFF_FLAGS) | hit(aw_addr_r, tpa_pkg::OFF_IRQEN)
		| hit(aw_addr_r, tpa_pkg::OFF_SFIO);
	wire [2:0] wr_slot = {wr_en & hit(aw_addr_r, tpa_pkg::OFF_COUNT),
		wr_en & hit(aw_addr_r, tpa_pkg::OFF_COMPARE), wr_en & hit(aw_addr_r, tpa_pkg::OFF_CTRL)};
	wire wr_asr = wr_en & hit(aw_addr_r, tpa_pkg::OFF_ASR);
	wire wr_flags = wr_en & hit(aw_addr_r, tpa_pkg::OFF_FLAGS);
	wire wr_irqen = wr_en & hit(aw_addr_r, tpa_pkg::OFF_IRQEN);
	wire wr_sfio = wr_en & hit(aw_addr_r, tpa_pkg::OFF_SFIO);

	// Read selection
	wire [31:0] rd_word = hit(s_axi_araddr, tpa_pkg::OFF_CTRL) ? {25'h0, ctl_r}
		: hit(s_axi_araddr, tpa_pkg::OFF_COUNT) ? {24'h0, cnt_copy_r}
		: hit(s_axi_araddr, tpa_pkg::OFF_COMPARE) ? {24'h0, cmp_r}
		: hit(s_axi_araddr, tpa_pkg::OFF_ASR) ? {28'h0, async_sel_r, busy_r}
		: hit(s_axi_araddr, tpa_pkg::OFF_FLAGS) ? {30'h0, flags_r}
		: hit(s_axi_araddr, tpa_pkg::OFF_IRQEN) ? {30'h0, irqen_r}
		: 32'h00000000;
	wire rd_map = hit(s_axi_araddr, tpa_pkg::OFF_CTRL) | hit(s_axi_araddr, tpa_pkg::OFF_COUNT)
		| hit(s_axi_araddr, tpa_pkg::OFF_COMPARE) | hit(s_axi_araddr, tpa_pkg::OFF_ASR)
		| hit(s_axi_araddr, tpa_pkg::OFF_FLAGS) | hit(s_axi_araddr, tpa_pkg::OFF_IRQEN)
		| hit(s_axi_araddr, tpa_pkg::OFF_SFIO);

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			aw_hold_r <= 1'b0;
			w_hold_r <= 1'b0;
			aw_addr_r <= 8'h00;
			w_data_r <= 8'h00;
			w_strb0_r <= 1'b0;
			awready_r <= 1'b0;
			wready_r <= 1'b0;
			bvalid_r <= 1'b0;
			bresp_r <= tpa_pkg::AXI_OKAY;
		end else begin
			aw_hold_r <= aw_hold_nxt;
			w_hold_r <= w_hold_nxt;
			awready_r <= ~aw_hold_nxt;
			wready_r <= ~w_hold_nxt;
			bvalid_r <= bvalid_nxt;
			if (aw_take) begin
				aw_addr_r <= s_axi_awaddr;
			end
			if (w_take) begin
				w_data_r <= s_axi_wdata[7:0];
				w_strb0_r <= s_axi_wstrb[0];
			end
			if (wr_do) begin
				bresp_r <= wr_map ? tpa_pkg::AXI_OKAY : tpa_pkg::AXI_SLVERR;
			end
		end
	end

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			arready_r <= 1'b0;
			rvalid_r <= 1'b0;
			rdata_r <= 32'h00000000;
			rresp_r <= tpa_pkg::AXI_OKAY;
		end else begin
			arready_r <= ~rvalid_nxt;
			rvalid_r <= rvalid_nxt;
			if (ar_take) begin
				rdata_r <= rd_word;
				rresp_r <= rd_map ? tpa_pkg::AXI_OKAY : tpa_pkg::AXI_SLVERR;
			end
		end
	end

	// Crystal input synchroniser and rising-edge detect
	wire xtal_rise = xs2_r & ~xs3_r;

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			xs1_r <= 1'b0;
			xs2_r <= 1'b0;
			xs3_r <= 1'b0;
		end else begin
			xs1_r <= crystal_osc_in;
			xs2_r <= xs1_r;
			xs3_r <= xs2_r;
		end
	end

	// Timer source clock and prescaler hookup
	assign pif.src_tick = async_sel_r ? xtal_rise : 1'b1;
	assign pif.clr = psr_r;
	assign pif.sel = tpa_pkg::tpa_cs_t'(ctl_r[tpa_pkg::CTRL_CS_LSB +: 3]);

	// Async write slots: temp value, busy flag, crystal edge count
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			for (int i = 0; i < 3; i++) begin
				tmp_r[i] <= 8'h00;
				edg_r[i] <= 2'h0;
			end
			busy_r <= 3'h0;
		end else begin
			for (int i = 0; i < 3; i++) begin
				if (wr_slot[i] && async_sel_r) begin
					tmp_r[i] <= w_data_r;
					edg_r[i] <= 2'h0;
					busy_r[i] <= 1'b1;
				end else if (lat[i]) begin
					busy_r[i] <= 1'b0;
				end else if (busy_r[i] && xtal_rise) begin
					edg_r[i] <= edg_r[i] + 2'h1;
				end
			end
		end
	end

	for (genvar g = 0; g < 3; g++) begin : g_lat
		assign lat[g] = busy_r[g] & xtal_rise & ~wr_slot[g] & (edg_r[g] == tpa_pkg::LATCH_EDGES - 2'h1);
	end

	// Counter sequencing
	wire phase_mode = {ctl_r[tpa_pkg::CTRL_WGM1_BIT], ctl_r[tpa_pkg::CTRL_WGM0_BIT]} == tpa_pkg::WGM_PHASE;
	wire [1:0] com = ctl_r[tpa_pkg::CTRL_COM_LSB +: 2];
	wire cnt_load = (wr_slot[tpa_pkg::IDX_CNT] & ~async_sel_r) | lat[tpa_pkg::IDX_CNT];
	wire [7:0] cnt_load_val = async_sel_r ? tmp_r[tpa_pkg::IDX_CNT] : w_data_r;
	wire step_up = ~phase_mode | (cnt_r == tpa_pkg::BOTTOM) | (dir_up_r & (cnt_r != tpa_pkg::MAX));
	wire [7:0] nc = step_up ? cnt_r + 8'h01 : cnt_r - 8'h01;
	wire tick = pif.tick & ~cnt_load;
	wire cmp_block = busy_r[tpa_pkg::IDX_CNT] | busy_r[tpa_pkg::IDX_CMP];
	wire ev_cmp = tick & (nc == cmp_r) & ~cmp_block;
	wire ev_ovf = tick & (phase_mode ? (nc == tpa_pkg::BOTTOM) : (cnt_r == tpa_pkg::MAX));
	wire up_res = (com == tpa_pkg::COM_INV);

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			cnt_r <= tpa_pkg::COUNT_RESET;
			dir_up_r <= 1'b1;
		end else if (cnt_load) begin
			cnt_r <= cnt_load_val;
		end else if (tick) begin
			cnt_r <= nc;
			dir_up_r <= (nc == tpa_pkg::MAX) ? 1'b0 : (nc == tpa_pkg::BOTTOM) ? 1'b1 : step_up;
		end
	end

	// Control, compare and software registers
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			ctl_r <= tpa_pkg::CTRL_RESET;
			cmp_r <= tpa_pkg::COMPARE_RESET;
			async_sel_r <= 1'b0;
			irqen_r <= tpa_pkg::IRQEN_RESET;
			psr_r <= 1'b0;
		end else begin
			if (wr_slot[tpa_pkg::IDX_CTL] && !async_sel_r) begin
				ctl_r <= w_data_r[6:0];
			end else if (lat[tpa_pkg::IDX_CTL]) begin
				ctl_r <= tmp_r[tpa_pkg::IDX_CTL][6:0];
			end
			if (wr_slot[tpa_pkg::IDX_CMP] && !async_sel_r) begin
				cmp_r <= w_data_r;
			end else if (lat[tpa_pkg::IDX_CMP]) begin
				cmp_r <= tmp_r[tpa_pkg::IDX_CMP];
			end
			if (wr_asr) begin
				async_sel_r <= w_data_r[tpa_pkg::ASR_ASYNC_BIT];
			end
			if (wr_irqen) begin
				irqen_r <= w_data_r[1:0];
			end
			psr_r <= wr_sfio & w_data_r[tpa_pkg::SFIO_PSR_BIT];
		end
	end

	// Waveform output; BOTTOM counts as up match, MAX chosen by compare value
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			out_lvl_r <= 1'b0;
			pin_r <= 1'b0;
			conn_r <= 1'b0;
		end else begin
			if (tick && phase_mode && com[1]) begin
				if (nc == tpa_pkg::MAX) begin
					out_lvl_r <= (cmp_r == tpa_pkg::MAX) ? ~up_res : up_res;
				end else if (ev_cmp) begin
					out_lvl_r <= (step_up || nc == tpa_pkg::BOTTOM) ? up_res : ~up_res;
				end
			end
			pin_r <= out_lvl_r;
			conn_r <= com[1];
		end
	end

	// Flags with async sync pipe; set beats clear
	wire set_ovf = async_sel_r ? pipe_ovf_r[tpa_pkg::FLAG_SYNC_CYCLES - 1] : ev_ovf;
	wire set_cmp = async_sel_r ? pipe_cmp_r[tpa_pkg::FLAG_SYNC_CYCLES - 1] : ev_cmp;
	wire [1:0] flag_clr = wr_flags ? w_data_r[1:0] : 2'h0;
	wire irq_cond = |(flags_r & irqen_r);

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			pipe_ovf_r <= 3'h0;
			pipe_cmp_r <= 3'h0;
			flags_r <= 2'h0;
			cnt_copy_r <= tpa_pkg::COUNT_RESET;
		end else begin
			pipe_ovf_r <= {pipe_ovf_r[1:0], ev_ovf & async_sel_r};
			pipe_cmp_r <= {pipe_cmp_r[1:0], ev_cmp & async_sel_r};
			flags_r[tpa_pkg::FLAG_OVF_BIT] <= set_ovf
				| (flags_r[tpa_pkg::FLAG_OVF_BIT] & ~flag_clr[tpa_pkg::FLAG_OVF_BIT]);
			flags_r[tpa_pkg::FLAG_CMP_BIT] <= set_cmp
				| (flags_r[tpa_pkg::FLAG_CMP_BIT] & ~flag_clr[tpa_pkg::FLAG_CMP_BIT]);
			if (!async_sel_r || xtal_rise) begin
				cnt_copy_r <= cnt_r;
			end
		end
	end

	// Interrupt request, rearm and wake
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			rearm_r <= 1'b1;
			irq_r <= 1'b0;
			wake_arm_r <= 1'b0;
			wake_r <= 1'b0;
			osc_claim_r <= 1'b0;
		end else begin
			if (async_sel_r && flag_clr != 2'h0) begin
				rearm_r <= 1'b0;
			end else if (xtal_rise || !async_sel_r) begin
				rearm_r <= 1'b1;
			end
			irq_r <= irq_cond & rearm_r;
			wake_arm_r <= async_sel_r & irq_cond & rearm_r;
			wake_r <= wake_arm_r & xtal_rise;
			osc_claim_r <= async_sel_r;
		end
	end

	// Outputs
	assign s_axi_awready = awready_r;
	assign s_axi_wready = wready_r;
	assign s_axi_bvalid = bvalid_r;
	assign s_axi_bresp = bresp_r;
	assign s_axi_arready = arready_r;
	assign s_axi_rvalid = rvalid_r;
	assign s_axi_rdata = rdata_r;
	assign s_axi_rresp = rresp_r;
	assign compare_output_pin = pin_r;
	assign compare_output_connected = conn_r;
	assign osc_pins_claimed = osc_claim_r;
	assign timer_irq = irq_r;
	assign wake_req = wake_r;

	// Checks
	property p_max_reverse;
		@(posedge clk_sys) disable iff (!arst_n)
		(tick && phase_mode && cnt_r == tpa_pkg::MAX) |=> (cnt_r == 8'hFE && !dir_up_r);
	endproperty
	a_max_reverse: assert property (p_max_reverse) else $error("no reversal at MAX");

	property p_up_step;
		@(posedge clk_sys) disable iff (!arst_n)
		(tick && phase_mode && dir_up_r && cnt_r != tpa_pkg::MAX) |=> cnt_r == $past(cnt_r) + 8'h01;
	endproperty
	a_up_step: assert property (p_up_step) else $error("up count step wrong");

	property p_ovf_bottom;
		@(posedge clk_sys) disable iff (!arst_n)
		(ev_ovf && phase_mode && !async_sel_r) |=> flags_r[tpa_pkg::FLAG_OVF_BIT];
	endproperty
	a_ovf_bottom: assert property (p_ovf_bottom) else $error("overflow flag missed");

	property p_cmp_latch;
		@(posedge clk_sys) disable iff (!arst_n)
		lat[tpa_pkg::IDX_CMP] |=> (cmp_r == $past(tmp_r[tpa_pkg::IDX_CMP])) && !busy_r[tpa_pkg::IDX_CMP];
	endproperty
	a_cmp_latch: assert property (p_cmp_latch) else $error("compare not latched");

	property p_busy_set;
		@(posedge clk_sys) disable iff (!arst_n)
		(wr_slot[tpa_pkg::IDX_CMP] && async_sel_r) |=> busy_r[tpa_pkg::IDX_CMP] ##1 busy_r[tpa_pkg::IDX_CMP];
	endproperty
	a_busy_set: assert property (p_busy_set) else $error("busy not set");

	property p_no_match_busy;
		@(posedge clk_sys) disable iff (!arst_n)
		cmp_block |=> !pipe_cmp_r[0];
	endproperty
	a_no_match_busy: assert property (p_no_match_busy) else $error("match while busy");

	property p_flag_sync;
		@(posedge clk_sys) disable iff (!arst_n)
		(ev_ovf && async_sel_r) ##3 async_sel_r |-> set_ovf ##1 flags_r[tpa_pkg::FLAG_OVF_BIT];
	endproperty
	a_flag_sync: assert property (p_flag_sync) else $error("async flag timing");

	property p_copy_hold;
		@(posedge clk_sys) disable iff (!arst_n)
		(async_sel_r && !xtal_rise) |=> $stable(cnt_copy_r);
	endproperty
	a_copy_hold: assert property (p_copy_hold) else $error("copy changed off edge");

	property p_bottom_low;
		@(posedge clk_sys) disable iff (!arst_n)
		(tick && phase_mode && com == tpa_pkg::COM_NONINV && cmp_r == tpa_pkg::BOTTOM && !cmp_block)
			|=> !out_lvl_r;
	endproperty
	a_bottom_low: assert property (p_bottom_low) else $error("bottom compare not low");
endmodule

// file: shared/tpa_pkg.sv
// Constants, field positions and types for the phase-correct timer block.
// Assumes a single 250 MHz system clock; the crystal input is sampled on it.
package tpa_pkg;
	localparam int unsigned CLK_PERIOD_NS = 4;
	localparam int unsigned FLAG_SYNC_CYCLES = 3;
	localparam logic [1:0] LATCH_EDGES = 2'h2;
	// Register byte offsets
	localparam logic [7:0] OFF_CTRL = 8'h00;
	localparam logic [7:0] OFF_COUNT = 8'h04;
	localparam logic [7:0] OFF_COMPARE = 8'h08;
	localparam logic [7:0] OFF_ASR = 8'h0C;
	localparam logic [7:0] OFF_FLAGS = 8'h10;
	localparam logic [7:0] OFF_IRQEN = 8'h14;
	localparam logic [7:0] OFF_SFIO = 8'h18;
	// Control field positions
	localparam int unsigned CTRL_CS_LSB = 0;
	localparam int unsigned CTRL_WGM0_BIT = 3;
	localparam int unsigned CTRL_COM_LSB = 4;
	localparam int unsigned CTRL_WGM1_BIT = 6;
	// Async status bits; busy bits double as async slot indices
	localparam int unsigned IDX_CTL = 0;
	localparam int unsigned IDX_CMP = 1;
	localparam int unsigned IDX_CNT = 2;
	localparam int unsigned ASR_ASYNC_BIT = 3;
	// Flag and enable bit positions
	localparam int unsigned FLAG_OVF_BIT = 0;
	localparam int unsigned FLAG_CMP_BIT = 1;
	localparam int unsigned SFIO_PSR_BIT = 0;
	// Reset values
	localparam logic [6:0] CTRL_RESET = 7'h00;
	localparam logic [7:0] COUNT_RESET = 8'h00;
	localparam logic [7:0] COMPARE_RESET = 8'h00;
	localparam logic [1:0] IRQEN_RESET = 2'h0;
	// Counter limits and mode encodings
	localparam logic [7:0] BOTTOM = 8'h00;
	localparam logic [7:0] MAX = 8'hFF;
	localparam logic [1:0] WGM_PHASE = 2'h1;
	localparam logic [1:0] COM_OFF = 2'h0;
	localparam logic [1:0] COM_NONINV = 2'h2;
	localparam logic [1:0] COM_INV = 2'h3;
	localparam logic [1:0] AXI_OKAY = 2'h0;
	localparam logic [1:0] AXI_SLVERR = 2'h2;
	typedef enum logic [2:0] {
		CS_STOP = 3'b000,
		CS_DIV1 = 3'b001,
		CS_DIV8 = 3'b010,
		CS_DIV32 = 3'b011,
		CS_DIV64 = 3'b100,
		CS_DIV128 = 3'b101,
		CS_DIV256 = 3'b110,
		CS_DIV1024 = 3'b111
	} tpa_cs_t;
endpackage

// file: shared/tpa_presc_if.sv
// Link between the timer core and its prescaler.
// Assumes both ends run on clk_sys.
`timescale 1ns/100ps
interface tpa_presc_if;
	logic src_tick;
	logic clr;
	tpa_pkg::tpa_cs_t sel;
	logic tick;
	modport core (output src_tick, output clr, output sel, input tick);
	modport presc (input src_tick, input clr, input sel, output tick);
endinterface

// file: rtl/tpa_prescaler.sv
// Ten-bit prescaler producing the timer tick enable.
// Assumes src_tick is a one-cycle enable for each source clock period.
`timescale 1ns/100ps
module tpa_prescaler (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic arst_n,
	// Core side
	tpa_presc_if.presc pif
);
	logic [9:0] div_r;
	logic tap;

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			div_r <= 10'h000;
		end else if (pif.clr) begin
			div_r <= 10'h000;
		end else if (pif.src_tick) begin
			div_r <= div_r + 10'h001;
		end
	end

	// Tap fires on the last source tick of each divided period
	always_comb begin
		case (pif.sel)
			tpa_pkg::CS_STOP: tap = 1'b0;
			tpa_pkg::CS_DIV1: tap = 1'b1;
			tpa_pkg::CS_DIV8: tap = &div_r[2:0];
			tpa_pkg::CS_DIV32: tap = &div_r[4:0];
			tpa_pkg::CS_DIV64: tap = &div_r[5:0];
			tpa_pkg::CS_DIV128: tap = &div_r[6:0];
			tpa_pkg::CS_DIV256: tap = &div_r[7:0];
			tpa_pkg::CS_DIV1024: tap = &div_r[9:0];
			default: tap = 1'b0;
		endcase
	end

	assign pif.tick = pif.src_tick & tap & ~pif.clr;
endmodule

// file: sim/tpa_xtal_model.sv
// Stand-in for the watch crystal feeding the timer's asynchronous input.
// Assumes the system clock runs much faster than this oscillator.
`timescale 1ns/100ps
module tpa_xtal_model #(
	parameter int HALF_NS = 100
) (
	// Oscillator output
	output logic osc_out
);
	// Free-running, well under a quarter of the system clock rate
	initial begin
		osc_out = 1'b0;
		forever #(HALF_NS) osc_out = ~osc_out;
	end
endmodule

// file: sim/tpa_timer_tb.sv
// Self-checking bench for the phase-correct timer block.
// Assumes tpa_pkg is compiled first; the crystal model drives the async input.
`timescale 1ns/100ps
module tpa_timer_tb;
	logic clk_sys = 1'b0;
	logic arst_n = 1'b0;
	logic [7:0] awaddr = 8'h00;
	logic [7:0] araddr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic awvalid = 1'b0;
	logic wvalid = 1'b0;
	logic arvalid = 1'b0;
	logic awready, wready, bvalid, arready, rvalid;
	logic pin, conn, claimed, irq, wake, xtal;
	logic [1:0] bresp, rresp;
	logic [31:0] rdata;
	int n_mismatch = 0;
	int total_checks = 0;
	int cyc = 0;
	int n_rise = 0;
	int seed = 5;

	always #2 clk_sys = ~clk_sys;
	always @(posedge xtal) n_rise++;
	always @(posedge clk_sys) begin
		cyc++;
		if (cyc == 95000) begin
			n_mismatch++;
			wrap_up;
		end
	end

	tpa_timer dut_u (
		.clk_sys(clk_sys), .arst_n(arst_n),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(1'b1),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(1'b1),
		.crystal_osc_in(xtal), .compare_output_pin(pin), .compare_output_connected(conn),
		.osc_pins_claimed(claimed), .timer_irq(irq), .wake_req(wake)
	);

	tpa_xtal_model #(.HALF_NS(100)) xtal_u (.osc_out(xtal));

	task automatic wrap_up;
		$display("checks %0d mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("FAIL %s expected %h seen %h", nm, exp, got);
		end
	endtask

	// Write with both channels offered together; bready stays high
	task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		bit aw_done, w_done;
		aw_done = 0;
		w_done = 0;
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		while (!(aw_done && w_done)) begin
			@(posedge clk_sys);
			if (!aw_done && awready === 1'b1) begin
				aw_done = 1;
				awvalid <= 1'b0;
			end
			if (!w_done && wready === 1'b1) begin
				w_done = 1;
				wvalid <= 1'b0;
			end
		end
		do @(posedge clk_sys); while (bvalid !== 1'b1);
		r = bresp;
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		araddr <= a;
		arvalid <= 1'b1;
		do @(posedge clk_sys); while (arready !== 1'b1);
		arvalid <= 1'b0;
		do @(posedge clk_sys); while (rvalid !== 1'b1);
		d = rdata;
		r = rresp;
	endtask

	task automatic w(input logic [7:0] a, input logic [31:0] d);
		logic [1:0] r;
		wr(a, d, r);
		chk("bresp", r, tpa_pkg::AXI_OKAY);
	endtask

	task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] d;
		logic [1:0] r;
		rd(a, d, r);
		chk(nm, d, exp);
	endtask

	task automatic wait_idle;
		logic [31:0] d;
		logic [1:0] r;
		do rd(tpa_pkg::OFF_ASR, d, r); while (d[2:0] !== 3'b000);
	endtask

	// Model of the pin's high time over two full periods
	function automatic int hi_exp(int c, int m);
		return (m == 3) ? 1020 - 4 * c : 4 * c;
	endfunction

	initial begin
		logic [31:0] v;
		logic [1:0] r;
		int g, hi, q;
		int cmps[$];
		int divs[$];
		repeat (3) @(posedge clk_sys);
		arst_n <= 1'b1;
		@(posedge clk_sys);
		for (int a = 0; a <= 8'h18; a += 4) begin
			rchk("reset value", a[7:0], 32'h0);
		end
		wr(8'h40, 32'h1, r);
		chk("unmapped bresp", r, tpa_pkg::AXI_SLVERR);
		rd(8'h40, v, r);
		chk("unmapped rresp", r, tpa_pkg::AXI_SLVERR);
		w(tpa_pkg::OFF_CTRL, 32'hA9);
		rchk("ctrl", tpa_pkg::OFF_CTRL, 32'h29);
		cmps = '{0, 255, $random(seed) & 255, $random(seed) & 255};
		for (int i = 0; i < 4; i++) begin
			for (int m = 0; m < 4; m++) begin
				w(tpa_pkg::OFF_COMPARE, cmps[i]);
				w(tpa_pkg::OFF_CTRL, (m << 4) | 8'h09);
				repeat (2) @(posedge clk_sys);
				chk("connected", conn, m >= 2);
				if (m >= 2) begin
					repeat (520) @(posedge clk_sys);
					hi = 0;
					repeat (1020) begin
						@(posedge clk_sys);
						hi += (pin === 1'b1);
					end
					chk("high time", hi, hi_exp(cmps[i], m));
				end
			end
		end
		// Period of the waveform for three prescale settings
		divs = '{1, 8, 32};
		for (int k = 0; k < 3; k++) begin
			w(tpa_pkg::OFF_COMPARE, 32'h80);
			w(tpa_pkg::OFF_CTRL, 8'h28 | (k + 1));
			w(tpa_pkg::OFF_SFIO, 32'h1);
			rchk("sfio", tpa_pkg::OFF_SFIO, 32'h0);
			for (int e = 0; e < 2; e++) begin
				g = 0;
				do begin
					v[0] = pin;
					@(posedge clk_sys);
					g++;
				end while (!(pin === 1'b1 && v[0] === 1'b0));
			end
			chk("period", g, 510 * divs[k]);
		end
		w(tpa_pkg::OFF_CTRL, 32'h28);
		rd(tpa_pkg::OFF_COUNT, v, r);
		repeat (50) @(posedge clk_sys);
		rchk("stopped count", tpa_pkg::OFF_COUNT, v);
		rchk("flags", tpa_pkg::OFF_FLAGS, 32'h3);
		w(tpa_pkg::OFF_IRQEN, 32'h1);
		repeat (3) @(posedge clk_sys);
		chk("irq", irq, 1'b1);
		w(tpa_pkg::OFF_FLAGS, 32'h3);
		repeat (3) @(posedge clk_sys);
		chk("irq cleared", irq, 1'b0);
		rchk("flags cleared", tpa_pkg::OFF_FLAGS, 32'h0);
		// Safe switch to crystal clocking
		w(tpa_pkg::OFF_IRQEN, 32'h0);
		w(tpa_pkg::OFF_ASR, 32'h08);
		repeat (2) @(posedge clk_sys);
		chk("pins claimed", claimed, 1'b1);
		w(tpa_pkg::OFF_CTRL, 32'h08);
		wait_idle;
		v = $random(seed) & 255;
		q = n_rise;
		w(tpa_pkg::OFF_COMPARE, v);
		rchk("compare busy", tpa_pkg::OFF_ASR, 32'h0A);
		wait_idle;
		chk("crystal rises", (n_rise - q) >= 2, 1'b1);
		rchk("async compare", tpa_pkg::OFF_COMPARE, v);
		v = $random(seed) & 255;
		w(tpa_pkg::OFF_COUNT, v);
		wait_idle;
		repeat (100) @(posedge clk_sys);
		rchk("async count", tpa_pkg::OFF_COUNT, v);
		// Compare match under crystal clocking raises irq and wake
		w(tpa_pkg::OFF_COMPARE, 32'h1);
		w(tpa_pkg::OFF_COUNT, 32'h0);
		wait_idle;
		w(tpa_pkg::OFF_IRQEN, 32'h2);
		w(tpa_pkg::OFF_CTRL, 32'h09);
		wait_idle;
		hi = 0;
		repeat (300) begin
			@(posedge clk_sys);
			hi += (wake === 1'b1);
		end
		chk("wake", hi > 0, 1'b1);
		chk("async irq", irq, 1'b1);
		rchk("async flags", tpa_pkg::OFF_FLAGS, 32'h2);
		w(tpa_pkg::OFF_FLAGS, 32'h3);
		wrap_up;
	end
endmodule
